// ### common/sic_pkg.sv
// Shared constants and types of the simple I2C stop, rate and error channel
package sic_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int SIC_PRE_W = 11;
	localparam int SIC_DIV_W = 7;
	localparam int SIC_PSC_W = 4;
	localparam int SIC_BYTE_W = 8;
	localparam int SIC_SHIFT_W = 9;
	localparam int SIC_BITCNT_W = 4;
	localparam int SIC_FLAG_W = 2;

	// ----------------------------------------
	// Values and positions
	// ----------------------------------------
	localparam logic [SIC_PSC_W-1:0] SIC_PSC_MAX = 4'hB;
	localparam logic [SIC_DIV_W-1:0] SIC_DIV_ZERO = 7'h00;
	localparam logic [SIC_BITCNT_W-1:0] SIC_BIT_LAST = 4'h8;
	localparam logic [SIC_BITCNT_W-1:0] SIC_BIT_FIRST = 4'h0;
	localparam logic [SIC_BITCNT_W-1:0] SIC_BIT_STEP = 4'h1;
	localparam logic [SIC_DIV_W-1:0] SIC_DIV_STEP = 7'h01;
	localparam logic [SIC_PRE_W-1:0] SIC_PRE_STEP = 11'h001;
	localparam logic [SIC_PRE_W:0] SIC_PRE_ONE = 12'h001;
	localparam int SIC_FLAG_OVR = 0;
	localparam int SIC_FLAG_NACK = 1;
	localparam logic SIC_LATCH_RST = 1'b1;
	localparam logic SIC_SOE_RST = 1'b0;
	localparam logic SIC_ACK_RELEASE = 1'b1;
	localparam logic [SIC_BYTE_W-1:0] SIC_BYTE_RST = 8'h00;
	localparam logic [SIC_SHIFT_W-1:0] SIC_SHIFT_RST = 9'h1FF;
	localparam logic [SIC_FLAG_W-1:0] SIC_FLAG_RST = 2'h0;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		SIC_IDLE = 2'b00,
		SIC_LOW = 2'b01,
		SIC_HIGH = 2'b10
	} sic_state_t;

	typedef struct packed {
		logic [SIC_DIV_W-1:0] divider;
		logic prescaler_select_bit;
		logic [SIC_PSC_W-1:0] low_prescaler_field;
		logic [SIC_PSC_W-1:0] high_prescaler_field;
	} sic_cfg_t;

	typedef struct packed {
		logic channel_operating_status;
		logic busy;
		logic buffer_full_flag;
		logic [SIC_FLAG_W-1:0] error_flags;
		logic setting_illegal;
	} sic_stat_t;

endpackage : sic_pkg

// ### core/sic_channel.sv
// Simple I2C master channel: direct latch control, rate divider, error flags
// Summary of operation
// - Stop trigger clears operating status; clock latch then becomes directly writable.
// - With output enable cleared, software may drive the data latch low.
// - Clock latch high, wait, data latch high gives the stop condition.
// - Bus is released only by the stop condition after the last exchange.
// - During reception output enable is already cleared, data line stays released.
// - Bit rate is operating clock over divider plus one, halved.
// - Divider zero is prohibited and flagged; legal values are 1 to 127.
// - SCL has equal high and low halves after the first low half, each one divider period.
// - Select bit picks low or high prescaler field.
// - Reading the data register clears the buffer full flag.
// - Writing read status to clear trigger clears exactly those error flags.
// - After missing acknowledge, stop, restart, then start trigger sets status again.
// - No acknowledge is ever driven by this end; the ninth bit stays high on every byte.
`timescale 1ns/1ps

module sic_channel
	import sic_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// Channel control
	input wire logic channel_start_trigger,
	input wire logic channel_stop_trigger,
	input wire logic soe_wr,
	input wire logic soe_val,
	input wire logic clk_latch_wr,
	input wire logic clk_latch_val,
	input wire logic data_latch_wr,
	input wire logic data_latch_val,
	input wire sic_pkg::sic_cfg_t cfg,
	// Byte transfer
	input wire logic xfer_go,
	input wire logic [sic_pkg::SIC_BYTE_W-1:0] xfer_data,
	input wire logic rx_read,
	output logic [sic_pkg::SIC_BYTE_W-1:0] rx_data,
	// Error flag clear
	input wire logic flag_clear_wr,
	input wire logic [sic_pkg::SIC_FLAG_W-1:0] flag_clear_val,
	// Status
	output sic_pkg::sic_stat_t stat,
	output logic serial_output_enable,
	// Bus pins, open drain
	input wire logic sda_i,
	output logic scl_o,
	output logic scl_oe,
	output logic sda_o,
	output logic sda_oe
);
	import sic_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic channel_operating_status;
	logic clock_output_latch;
	logic data_output_latch;
	logic buffer_full_flag;
	logic [SIC_FLAG_W-1:0] error_flags;
	sic_state_t state;
	logic [SIC_SHIFT_W-1:0] tx_shift;
	logic [SIC_BYTE_W-1:0] rx_shift;
	logic [SIC_BITCNT_W-1:0] bit_cnt;
	logic [SIC_PRE_W-1:0] pre_cnt;
	logic [SIC_DIV_W-1:0] half_cnt;

	// ----------------------------------------
	// Operating clock and rate
	// ----------------------------------------
	logic [SIC_PSC_W-1:0] psc_k;
	logic [SIC_PRE_W-1:0] pre_mask;
	logic psc_ok;
	logic div_ok;
	logic op_tick;
	logic half_done;
	logic xfer_done;

	assign psc_k = cfg.prescaler_select_bit ? cfg.high_prescaler_field : cfg.low_prescaler_field;
	assign psc_ok = (psc_k <= SIC_PSC_MAX);
	assign pre_mask = SIC_PRE_W'((SIC_PRE_ONE << psc_k) - SIC_PRE_ONE);
	assign op_tick = ((pre_cnt & pre_mask) == pre_mask);
	assign div_ok = (cfg.divider != SIC_DIV_ZERO);
	assign half_done = op_tick && (half_cnt == cfg.divider);
	assign xfer_done = channel_operating_status && (state == SIC_HIGH) && half_done && (bit_cnt == SIC_BIT_LAST);

	// Free running, so a prescaler change takes effect within one wrap
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			pre_cnt <= '0;
		end else begin
			pre_cnt <= pre_cnt + SIC_PRE_STEP;
		end
	end

	// Half period counter, restarted at each SCL edge
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			half_cnt <= '0;
		end else if (state == SIC_IDLE || half_done) begin
			half_cnt <= '0;
		end else if (op_tick) begin
			half_cnt <= half_cnt + SIC_DIV_STEP;
		end
	end

	// ----------------------------------------
	// Channel operating status
	// ----------------------------------------
	// Stop wins over a simultaneous start
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			channel_operating_status <= 1'b0;
		end else if (channel_stop_trigger) begin
			channel_operating_status <= 1'b0;
		end else if (channel_start_trigger) begin
			channel_operating_status <= 1'b1;
		end
	end

	// ----------------------------------------
	// Serial output enable
	// ----------------------------------------
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			serial_output_enable <= SIC_SOE_RST;
		end else if (soe_wr) begin
			serial_output_enable <= soe_val;
		end
	end

	// ----------------------------------------
	// Bit engine and output latches
	// ----------------------------------------
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= SIC_IDLE;
			clock_output_latch <= SIC_LATCH_RST;
			data_output_latch <= SIC_LATCH_RST;
			tx_shift <= SIC_SHIFT_RST;
			rx_shift <= SIC_BYTE_RST;
			bit_cnt <= SIC_BIT_FIRST;
		end else begin
			// Data latch is software owned whenever the serial output is off
			if (data_latch_wr && !serial_output_enable) begin
				data_output_latch <= data_latch_val;
			end
			if (!channel_operating_status) begin
				// Halted: engine idle, clock latch directly controllable
				state <= SIC_IDLE;
				if (clk_latch_wr) begin
					clock_output_latch <= clk_latch_val;
				end
			end else begin
				unique case (state)
					SIC_IDLE: begin
						if (xfer_go && div_ok && psc_ok) begin
							// Ninth bit is a one so the acknowledge slot is released
							tx_shift <= {xfer_data, SIC_ACK_RELEASE};
							bit_cnt <= SIC_BIT_FIRST;
							clock_output_latch <= 1'b0;
							if (serial_output_enable) begin
								data_output_latch <= xfer_data[SIC_BYTE_W-1];
							end
							state <= SIC_LOW;
						end
					end
					SIC_LOW: begin
						if (half_done) begin
							clock_output_latch <= 1'b1;
							state <= SIC_HIGH;
						end
					end
					SIC_HIGH: begin
						if (half_done) begin
							clock_output_latch <= 1'b0;
							if (bit_cnt == SIC_BIT_LAST) begin
								// Clock parks low; only a stop sequence releases the bus
								state <= SIC_IDLE;
							end else begin
								rx_shift <= {rx_shift[SIC_BYTE_W-2:0], sda_i};
								bit_cnt <= bit_cnt + SIC_BIT_STEP;
								tx_shift <= {tx_shift[SIC_SHIFT_W-2:0], SIC_ACK_RELEASE};
								// With output off the line stays released, no acknowledge
								if (serial_output_enable) begin
									data_output_latch <= tx_shift[SIC_SHIFT_W-2];
								end
								state <= SIC_LOW;
							end
						end
					end
					default: begin
						state <= SIC_IDLE;
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// Received byte and buffer full
	// ----------------------------------------
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_data <= SIC_BYTE_RST;
		end else if (xfer_done) begin
			rx_data <= rx_shift;
		end
	end

	// Set wins over the clear by a read in the same cycle
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			buffer_full_flag <= 1'b0;
		end else if (xfer_done) begin
			buffer_full_flag <= 1'b1;
		end else if (rx_read) begin
			buffer_full_flag <= 1'b0;
		end
	end

	// ----------------------------------------
	// Error flags
	// ----------------------------------------
	logic [SIC_FLAG_W-1:0] flag_set;

	always_comb begin
		flag_set = SIC_FLAG_RST;
		flag_set[SIC_FLAG_OVR] = xfer_done && buffer_full_flag && !rx_read;
		// Acknowledge only checked while this end drives the data bits
		flag_set[SIC_FLAG_NACK] = xfer_done && serial_output_enable && sda_i;
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			error_flags <= SIC_FLAG_RST;
		end else begin
			// Clears only the flags named in the written value; new events survive
			error_flags <= (error_flags & ~(flag_clear_wr ? flag_clear_val : SIC_FLAG_RST)) | flag_set;
		end
	end

	// ----------------------------------------
	// Status and pins
	// ----------------------------------------
	always_comb begin
		stat.channel_operating_status = channel_operating_status;
		stat.busy = (state != SIC_IDLE);
		stat.buffer_full_flag = buffer_full_flag;
		stat.error_flags = error_flags;
		stat.setting_illegal = !div_ok || !psc_ok;
	end

	// Open drain: pull low while the latch is low, else release
	assign scl_o = 1'b0;
	assign scl_oe = !clock_output_latch;
	assign sda_o = 1'b0;
	assign sda_oe = !data_output_latch;

endmodule : sic_channel

// ### verification/sic_channel_sva.sv
// Assertions on the simple I2C channel ports
`timescale 1ns/1ps
module sic_channel_sva
	import sic_pkg::*;
(
	input wire logic mclk, sys_rst, soe_wr, soe_val, clk_latch_wr, clk_latch_val, channel_stop_trigger,
	input wire logic data_latch_wr, data_latch_val, rx_read, flag_clear_wr,
	input wire logic [sic_pkg::SIC_FLAG_W-1:0] flag_clear_val,
	input wire sic_pkg::sic_cfg_t cfg,
	input wire sic_pkg::sic_stat_t stat,
	input wire logic serial_output_enable, scl_oe, sda_oe
);
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	a_stop_halts: assert property (channel_stop_trigger |=> !stat.channel_operating_status)
		else $error("stop kept channel running");
	a_clk_latch: assert property (clk_latch_wr && !stat.channel_operating_status |=> scl_oe == !$past(clk_latch_val))
		else $error("clock latch write lost");
	a_data_latch: assert property (data_latch_wr && !serial_output_enable && !stat.busy |=>
		sda_oe == !$past(data_latch_val)) else $error("data latch write lost");
	a_soe_write: assert property (soe_wr |=> serial_output_enable == $past(soe_val))
		else $error("output enable write lost");
	a_rx_quiet: assert property (stat.busy && !serial_output_enable && !$past(serial_output_enable) &&
		!$past(data_latch_wr) |-> $stable(sda_oe)) else $error("data driven during reception");
	a_rx_clear: assert property (rx_read && !stat.busy |=> !stat.buffer_full_flag)
		else $error("buffer full not cleared");
	a_flag_clear: assert property (flag_clear_wr && !stat.busy |=>
		stat.error_flags == ($past(stat.error_flags) & ~$past(flag_clear_val))) else $error("flag clear wrong");
	a_illegal_set: assert property (stat.setting_illegal == (cfg.divider == 7'h00 ||
		(cfg.prescaler_select_bit ? cfg.high_prescaler_field : cfg.low_prescaler_field) > 4'hB))
		else $error("illegal setting flag wrong");
	c_nack: cover property (stat.error_flags[1]);
	c_overrun: cover property (stat.error_flags[0]);
	c_stop: cover property (!scl_oe && $fell(sda_oe));
endmodule : sic_channel_sva
bind sic_channel sic_channel_sva u_sva (.*);

// ### verification/sic_slave_model.sv
// Behavioural I2C slave on the far side of the two-wire bus
`timescale 1ns/1ps
module sic_slave_model (
	input wire logic scl, sda, ack_en, tx_en,
	input wire logic [7:0] tx_byte,
	output logic sda_pull,
	output logic [7:0] rx_byte
);
	int nr = 0;
	initial sda_pull = 1'b0;
	initial rx_byte = 8'h00;
	// Changes only while SCL is low; after the ninth bit releases unless tx_en drives the next byte's first bit
	always @(negedge scl, tx_byte, tx_en) if (!scl) sda_pull <= nr < 8 ? tx_en && !tx_byte[7 - nr] : ack_en && nr == 8;
	always @(posedge scl) begin
		if (nr < 8) rx_byte <= {rx_byte[6:0], sda};
		nr <= nr == 8 ? 0 : nr + 1;
	end
	// Delay avoids a race with a master bit change at an SCL fall
	always @(posedge sda) #1 if (scl) nr <= 0;
endmodule : sic_slave_model

// ### verification/test_simple_i2c_stop_rate_error.sv
// Self-checking bench of the simple I2C channel
`timescale 1ns/1ps
module test_simple_i2c_stop_rate_error;
	import sic_pkg::*;
	logic mclk = '0, sys_rst = '1, channel_start_trigger = '0, channel_stop_trigger = '0, soe_wr = '0, soe_val = '0;
	logic clk_latch_wr = '0, clk_latch_val = '0, data_latch_wr = '0, data_latch_val = '0, xfer_go = '0, rx_read = '0;
	logic flag_clear_wr = '0, ack_en = '1, tx_en = '0, serial_output_enable, scl_o, scl_oe, sda_o, sda_oe, sda_pull;
	logic [1:0] flag_clear_val = '0;
	logic [7:0] xfer_data = '0, tx_byte = '0, rx_data, slave_rx;
	logic [31:0] seed = 32'h14B90D79;
	sic_cfg_t cfg = '0;
	sic_stat_t stat;
	int miscompares = 0, checked = 0, cycles = 0, half;
	wire logic scl = !scl_oe;
	wire logic sda_i = !(sda_oe || sda_pull);
	sic_channel DUT (.*);
	sic_slave_model u_slave (.scl(scl), .sda(sda_i), .ack_en(ack_en), .tx_en(tx_en), .tx_byte(tx_byte),
		.sda_pull(sda_pull), .rx_byte(slave_rx));
	// Clock source never changes during the run
	initial forever #2 mclk = ~mclk;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : tick
	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
	endtask : pulse
	task automatic chk(input string what, input logic [15:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic test_done;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : test_done
	// Measures every SCL half after the first, which may be short
	task automatic xfer(input logic [7:0] d);
		int w, b;
		logic last;
		xfer_data = d;
		pulse(xfer_go);
		w = 0;
		b = 0;
		last = scl_oe;
		while (stat.busy === 1'b1 && w < 5000) begin
			tick(1);
			w++;
			if (scl_oe !== last) begin
				if (b > 0) chk("scl half", w, half);
				b++;
				w = 0;
				last = scl_oe;
			end
		end
		chk("scl halves", b, 18);
	endtask : xfer
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			test_done();
		end
	end
	initial begin
		tick(6);
		sys_rst = 1'b0;
		chk("reset", {stat, scl_oe, sda_oe, serial_output_enable}, 9'h008);
		soe_val = 1'b1;
		pulse(soe_wr);
		pulse(channel_start_trigger);
		for (int i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			cfg.divider = {4'h0, seed[2:0] | 3'h1};
			cfg.prescaler_select_bit = i[0];
			cfg.low_prescaler_field = i[0] ? 4'hF : 4'(i % 3);
			cfg.high_prescaler_field = i[0] ? 4'(i % 3) : 4'hF;
			half = (cfg.divider + 1) << (i % 3);
			xfer(seed[15:8]);
			chk("slave byte", slave_rx, seed[15:8]);
			chk("ack flags", stat.error_flags, 0);
			// Every completed byte fills the buffer; read it so no overrun follows
			pulse(rx_read);
		end
		ack_en = 1'b0;
		xfer(8'hA5);
		chk("nack", stat.error_flags, 2'h2);
		pulse(rx_read);
		flag_clear_val = stat.error_flags;
		pulse(flag_clear_wr);
		chk("nack clear", stat.error_flags, 0);
		clk_latch_val = 1'b1;
		pulse(clk_latch_wr);
		chk("latch refused", scl_oe, 1);
		pulse(channel_stop_trigger);
		chk("halted", stat.channel_operating_status, 0);
		soe_val = 1'b0;
		pulse(soe_wr);
		pulse(data_latch_wr);
		chk("sda low", sda_oe, 1);
		pulse(clk_latch_wr);
		chk("scl high", {scl_oe, sda_oe}, 2'h1);
		tick(4);
		data_latch_val = 1'b1;
		pulse(data_latch_wr);
		chk("stop", {scl, sda_i}, 2'h3);
		pulse(channel_start_trigger);
		chk("restart", stat.channel_operating_status, 1);
		tx_en = 1'b1;
		for (int i = 0; i < 2; i++) begin
			seed = lfsr(seed);
			tx_byte = seed[7:0];
			xfer(8'hFF);
			chk("rx byte", rx_data, tx_byte);
			chk("rx flags", {stat.buffer_full_flag, stat.error_flags}, {2'h2, i[0]});
		end
		pulse(rx_read);
		chk("buffer read", stat.buffer_full_flag, 0);
		for (int i = 2; i > 0; i--) begin
			flag_clear_val = 2'(i);
			pulse(flag_clear_wr);
			chk("ovr clear", stat.error_flags, i - 1);
		end
		cfg.divider = 7'h00;
		pulse(xfer_go);
		chk("div zero", {stat.setting_illegal, stat.busy}, 2'h2);
		cfg = {7'h03, 1'b0, 4'hC, 4'h0};
		pulse(xfer_go);
		chk("k twelve", {stat.setting_illegal, stat.busy}, 2'h2);
		cfg.low_prescaler_field = 4'hB;
		tick(1);
		chk("k eleven", stat.setting_illegal, 0);
		test_done();
	end
endmodule : test_simple_i2c_stop_rate_error
